// ===== mrsh_rx_status.sv
// Functional notes
// R1: Freeze selected and pin high halts tx/rx machines and the four MAC timers.
// R2: Operation resumes on the first clock edge after freeze deasserts.
// R3: Transmit block selected and asserted prevents any transmission start.
// R4: A mode bit selects freeze or transmit block for the shared pin.
// R5: Frame type codes 00000 quiet, 00001..00110 claim to implementor, 00111 reserved.
// R6: Start delimiter gives 010xx for short and 011xx for long addresses.
// R7: Start delimiter status appears two clocks after the JK byte.
// R8: Frame type reported only for valid frames with E received reset.
// R9: Frame type status appears two clocks after the ending delimiter byte.
// R10: Own source address gives code 10 plus E, A, C bits.
// R11: Own frame status follows frame type, three clocks after ending delimiter.
// R12: E line low when E received reset, otherwise high.
// R13: A and C lines high when set, low when reset.
// R14: A or C neither set nor reset forces A low and C high.
// R15: Tokens give 11000, 11001 repeated and 11010, 11011 captured.
// R16: Token status appears three clocks after the token ending delimiter byte.
// R17: Ring going operational gives 11100, going not operational gives 11101.
// R18: Ring change yields to other status and follows it next cycle.
// R19: Destination match with storage failure gives 11110 after frame type.
// R20: Each non-quiet code lasts exactly one clock.
// R21: Status lines are quiet after reset.
// R22: Outside logic decodes frame type then only the top two bits.
// R23: All logic runs on the network byte clock.
// R24: Asynchronous reset initialises all state.
// R25: External active-low destination match counts toward missed frame.
// R26: Reserved codes 00111 and 11111 are never driven.
// R27: Colliding status codes go out in successive cycles by offset order.
`include "mrsh_cfg.svh"

module mrsh_rx_status (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 freeze_select_i,
  input  wire logic                 freeze_or_tx_block_pin_i,
  input  wire logic                 tx_start_req_i,
  output logic                      freeze_o,
  output logic                      tx_start_o,
  input  wire logic                 sd_rcvd_i,
  input  wire logic                 sd_long_addr_i,
  input  wire logic                 frame_end_i,
  input  wire logic                 frame_valid_i,
  input  wire mrsh_pkg::mrsh_frame_e frame_type_i,
  input  wire logic                 own_sa_match_i,
  input  wire mrsh_pkg::mrsh_ind_e  e_ind_i,
  input  wire mrsh_pkg::mrsh_ind_e  a_ind_i,
  input  wire mrsh_pkg::mrsh_ind_e  c_ind_i,
  input  wire logic                 dest_match_i,
  input  wire logic                 ext_dest_match_in_n_i,
  input  wire logic                 buffer_store_fail_i,
  input  wire logic                 token_end_i,
  input  wire logic                 token_restricted_i,
  input  wire logic                 token_captured_i,
  input  wire logic                 ring_operational_i,
  output logic [`MRSH_RS_W-1:0]     rx_status_lines_o
);
  import mrsh_pkg::*;

  // ---------------------------------------------------------------
  // Code builders
  // ---------------------------------------------------------------
  function automatic mrsh_code_t own_code_f(input mrsh_ind_e e,
                                            input mrsh_ind_e a,
                                            input mrsh_ind_e c);
    logic eb;
    logic ab;
    logic cb;
    eb = (e != MRSH_IND_RESET);
    ab = (a == MRSH_IND_SET);
    cb = (c == MRSH_IND_SET);
    if ((a == MRSH_IND_OTHER) || (c == MRSH_IND_OTHER)) begin
      ab = 1'b0;
      cb = 1'b1;
    end
    return `MRSH_RS_OWN_BASE | {2'h0, eb, ab, cb};
  endfunction

  function automatic logic ft_ok_f(input logic valid, input mrsh_ind_e e, input mrsh_frame_e t);
    return valid && (e == MRSH_IND_RESET) && (t != MRSH_FT_NONE) && (t != MRSH_FT_RSVD);
  endfunction

  function automatic mrsh_code_t tok_code_f(input logic captured, input logic restricted);
    return `MRSH_RS_TOK_BASE | {3'h0, captured, restricted};
  endfunction

  // ---------------------------------------------------------------
  // Freeze and transmit block
  // ---------------------------------------------------------------
  assign freeze_o   = freeze_select_i && freeze_or_tx_block_pin_i;   // R1 R2 R4
  assign tx_start_o = tx_start_req_i && !freeze_or_tx_block_pin_i;  // R3

  // ---------------------------------------------------------------
  // Event capture
  // ---------------------------------------------------------------
  localparam int EV_W = 25;

  mrsh_state_s                               st_r;
  mrsh_state_s                               st_nxt;
  logic                                      sd_ev;
  mrsh_code_t                                sd_code;
  logic                                      ft_ev;
  mrsh_code_t                                ft_code;
  logic                                      own_ev;
  mrsh_code_t                                own_code;
  logic                                      ext_match;
  logic                                      miss_ev;
  mrsh_code_t                                tok_code;
  logic [EV_W-1:0]                           ev_in;
  logic [`MRSH_PIPE_DEPTH-1:0][EV_W-1:0]     ev_taps;
  logic [EV_W-1:0]                           ev1;
  logic [EV_W-1:0]                           ev2;
  logic [`MRSH_NCLS-1:0]                     arr;
  mrsh_code_t [`MRSH_NCLS-1:0]               arr_code;
  logic                                      ring_chg;

  assign sd_ev     = sd_rcvd_i;
  assign sd_code   = sd_long_addr_i ? `MRSH_RS_SD_LONG : `MRSH_RS_SD_SHORT;   // R6
  assign ft_ev     = frame_end_i && ft_ok_f(frame_valid_i, e_ind_i, frame_type_i);  // R8 R26
  assign ft_code   = {2'h0, frame_type_i};                                   // R5
  assign own_ev    = frame_end_i && own_sa_match_i;                          // R10
  assign own_code  = own_code_f(e_ind_i, a_ind_i, c_ind_i);                  // R12 R13 R14
  assign ext_match = st_r.ext_seen || !ext_dest_match_in_n_i;                // R25
  assign miss_ev   = frame_end_i && buffer_store_fail_i && (dest_match_i || ext_match);  // R19
  assign tok_code  = tok_code_f(token_captured_i, token_restricted_i);      // R15

  assign ev_in = {sd_ev, sd_code, ft_ev, ft_code, own_ev, own_code, miss_ev, token_end_i, tok_code};

  mrsh_dly #(
    .W     (EV_W),
    .DEPTH (`MRSH_PIPE_DEPTH)
  ) u_dly (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (ev_in),
    .taps_o  (ev_taps)
  );

  assign ev1 = ev_taps[`MRSH_DLY_SD-2];
  assign ev2 = ev_taps[`MRSH_DLY_OWN-2];

  // ---------------------------------------------------------------
  // Arrivals at their due cycle
  // ---------------------------------------------------------------
  assign ring_chg = (ring_operational_i != st_r.ring_prev);  // R17

  always_comb begin
    arr                      = '0;
    arr_code                 = '0;
    arr[`MRSH_CLS_SD]        = ev1[24];                      // R7
    arr_code[`MRSH_CLS_SD]   = ev1[23:19];
    arr[`MRSH_CLS_FT]        = ev1[18];                      // R9
    arr_code[`MRSH_CLS_FT]   = ev1[17:13];
    arr[`MRSH_CLS_OWN]       = ev2[12];                      // R11
    arr_code[`MRSH_CLS_OWN]  = ev2[11:7];
    arr[`MRSH_CLS_MISS]      = ev2[6];                       // R19
    arr_code[`MRSH_CLS_MISS] = `MRSH_RS_MISSED;
    arr[`MRSH_CLS_TOK]       = ev2[5];                       // R16
    arr_code[`MRSH_CLS_TOK]  = ev2[4:0];
    arr[`MRSH_CLS_RING]      = ring_chg;
    arr_code[`MRSH_CLS_RING] = ring_operational_i ? `MRSH_RS_RING_UP : `MRSH_RS_RING_DOWN;
  end

  // ---------------------------------------------------------------
  // Priority presentation
  // ---------------------------------------------------------------
  always_comb begin
    logic found;
    found            = 1'b0;
    st_nxt           = st_r;
    st_nxt.rs        = `MRSH_RS_QUIET;                       // R20
    st_nxt.ring_prev = ring_operational_i;
    if (sd_rcvd_i) begin
      st_nxt.ext_seen = 1'b0;
    end
    if (!ext_dest_match_in_n_i) begin
      st_nxt.ext_seen = 1'b1;                                // R25
    end
    for (int i = 0; i < `MRSH_NCLS; i++) begin
      if (arr[i]) begin
        st_nxt.code[i] = arr_code[i];
      end
      st_nxt.pend[i] = st_r.pend[i] || arr[i];
      if (st_nxt.pend[i] && !found) begin
        found          = 1'b1;                               // R18 R27
        st_nxt.rs      = st_nxt.code[i];
        st_nxt.pend[i] = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin        // R23
    if (reset_i) begin
      st_r <= '0;                                            // R21 R24
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rx_status_lines_o = st_r.rs;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_ft_cause;
    frame_end_i && ft_ok_f(frame_valid_i, e_ind_i, frame_type_i) && !sd_rcvd_i;
  endsequence

  sequence s_own_cause;
    frame_end_i && own_sa_match_i && ft_ok_f(frame_valid_i, e_ind_i, frame_type_i)
      && !sd_rcvd_i && !token_end_i ##1 !sd_rcvd_i && !frame_end_i;
  endsequence

  sequence s_tok_cause;
    token_end_i && !frame_end_i ##1 !sd_rcvd_i && !frame_end_i;
  endsequence

  sequence s_miss_cause;
    frame_end_i && buffer_store_fail_i && dest_match_i && !own_sa_match_i && !token_end_i
      && !ft_ok_f(frame_valid_i, e_ind_i, frame_type_i) ##1 !sd_rcvd_i && !frame_end_i;
  endsequence

  a_quiet_after_reset: assert property (@(posedge clk_i) disable iff (reset_i) // R21
    $past(reset_i) |-> (rx_status_lines_o == `MRSH_RS_QUIET))
    else $error("status not quiet after reset");

  a_no_reserved_code: assert property (@(posedge clk_i) disable iff (reset_i) // R26
    (rx_status_lines_o != `MRSH_RS_RSVD_FT) && (rx_status_lines_o != `MRSH_RS_RSVD_TOP))
    else $error("reserved status code driven");

  a_code_one_cycle: assert property (@(posedge clk_i) disable iff (reset_i) // R20
    (rx_status_lines_o != `MRSH_RS_QUIET) |=> (rx_status_lines_o != $past(rx_status_lines_o)))
    else $error("status code held longer than one cycle");

  a_ft_timing: assert property (@(posedge clk_i) disable iff (reset_i) // R9
    s_ft_cause |-> ##2 (rx_status_lines_o == {2'h0, $past(frame_type_i, 2)}))
    else $error("frame type status wrong or late");

  a_sd_timing: assert property (@(posedge clk_i) disable iff (reset_i) // R7
    (sd_rcvd_i && !frame_end_i) |-> ##2
      (rx_status_lines_o[4:2] == ($past(sd_long_addr_i, 2) ? 3'h3 : 3'h2)))
    else $error("start delimiter status wrong or late");

  a_own_follows_ft: assert property (@(posedge clk_i) disable iff (reset_i) // R11
    s_own_cause |-> ##1 (rx_status_lines_o[4:3] == 2'h0) ##1 (rx_status_lines_o[4:3] == 2'h2))
    else $error("own frame status does not follow frame type");

  a_own_eac_bits: assert property (@(posedge clk_i) disable iff (reset_i) // R14
    s_own_cause |-> ##2 (rx_status_lines_o == $past(own_code_f(e_ind_i, a_ind_i, c_ind_i), 3)))
    else $error("own frame indicator bits wrong");

  a_token_timing: assert property (@(posedge clk_i) disable iff (reset_i) // R16
    s_tok_cause |-> ##2
      (rx_status_lines_o == tok_code_f($past(token_captured_i, 3), $past(token_restricted_i, 3))))
    else $error("token status wrong or late");

  a_missed_frame: assert property (@(posedge clk_i) disable iff (reset_i) // R19
    s_miss_cause |-> ##2 (rx_status_lines_o == `MRSH_RS_MISSED))
    else $error("missed frame status wrong or late");

  a_ring_reported: assert property (@(posedge clk_i) disable iff (reset_i) // R17
    (ring_operational_i != $past(ring_operational_i)) && !$past(reset_i) |-> ##[1:6]
      (rx_status_lines_o == `MRSH_RS_RING_UP || rx_status_lines_o == `MRSH_RS_RING_DOWN))
    else $error("ring change not reported");

  a_ring_yields: assert property (@(posedge clk_i) disable iff (reset_i) // R18
    (ring_chg && (st_r.pend[`MRSH_NCLS-2:0] != '0 || arr[`MRSH_NCLS-2:0] != '0)) |=>
      (rx_status_lines_o != `MRSH_RS_RING_UP) && (rx_status_lines_o != `MRSH_RS_RING_DOWN))
    else $error("ring status did not yield");

  a_freeze_halts: assert property (@(posedge clk_i) disable iff (reset_i) // R1
    (freeze_select_i && freeze_or_tx_block_pin_i) |-> freeze_o && !tx_start_o)
    else $error("freeze not applied");

  a_tx_block: assert property (@(posedge clk_i) disable iff (reset_i) // R3
    (!freeze_select_i && freeze_or_tx_block_pin_i) |-> !tx_start_o && !freeze_o)
    else $error("transmit start while blocked");

  a_freeze_release: assert property (@(posedge clk_i) disable iff (reset_i) // R2
    $fell(freeze_or_tx_block_pin_i) |-> !freeze_o && (tx_start_o == tx_start_req_i))
    else $error("operation not resumed after freeze");

  a_sd_low_bits: assert property (@(posedge clk_i) disable iff (reset_i) // R6
    (rx_status_lines_o[4:3] == 2'h1) |-> (rx_status_lines_o[1:0] == 2'h0))
    else $error("start delimiter status low bits not zero");

  a_ft_has_cause: assert property (@(posedge clk_i) disable iff (reset_i) // R8
    (rx_status_lines_o inside {[5'h01:5'h06]}) |-> $past(frame_end_i && ft_ok_f(frame_valid_i, e_ind_i, frame_type_i), 2))
    else $error("frame type status without a valid frame");

  a_ext_latch_set: assert property (@(posedge clk_i) disable iff (reset_i) // R25
    !ext_dest_match_in_n_i |=> st_r.ext_seen)
    else $error("external match not latched");

  a_ring_direction: assert property (@(posedge clk_i) disable iff (reset_i) // R17
    (rx_status_lines_o[4:1] == 4'he) |-> (rx_status_lines_o[0] == !st_r.ring_prev))
    else $error("ring status direction wrong");

endmodule

// ===== mrsh_cfg.svh
`ifndef MRSH_CFG_SVH
`define MRSH_CFG_SVH

// ---------------------------------------------------------------
// Receive status codes
// ---------------------------------------------------------------
`define MRSH_RS_W          5
`define MRSH_RS_QUIET      5'h00
`define MRSH_RS_RSVD_FT    5'h07
`define MRSH_RS_SD_SHORT   5'h08
`define MRSH_RS_SD_LONG    5'h0c
`define MRSH_RS_OWN_BASE   5'h10
`define MRSH_RS_TOK_BASE   5'h18
`define MRSH_RS_RING_UP    5'h1c
`define MRSH_RS_RING_DOWN  5'h1d
`define MRSH_RS_MISSED     5'h1e
`define MRSH_RS_RSVD_TOP   5'h1f

// ---------------------------------------------------------------
// Status classes, index order is presentation priority
// ---------------------------------------------------------------
`define MRSH_NCLS          6
`define MRSH_CLS_FT        0
`define MRSH_CLS_SD        1
`define MRSH_CLS_OWN       2
`define MRSH_CLS_MISS      3
`define MRSH_CLS_TOK       4
`define MRSH_CLS_RING      5

// ---------------------------------------------------------------
// Timing, byte clocks from the triggering byte to the status
// ---------------------------------------------------------------
`define MRSH_DLY_SD        2
`define MRSH_DLY_FT        2
`define MRSH_DLY_OWN       3
`define MRSH_DLY_TOK       3
`define MRSH_PIPE_DEPTH    2

`endif

// ===== mrsh_pkg.sv
`include "mrsh_cfg.svh"

package mrsh_pkg;

  // ---------------------------------------------------------------
  // Indicator symbol classes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MRSH_IND_RESET = 2'h0,
    MRSH_IND_SET   = 2'h1,
    MRSH_IND_OTHER = 2'h2
  } mrsh_ind_e;

  // ---------------------------------------------------------------
  // Frame types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MRSH_FT_NONE   = 3'h0,
    MRSH_FT_CLAIM  = 3'h1,
    MRSH_FT_BEACON = 3'h2,
    MRSH_FT_VOID   = 3'h3,
    MRSH_FT_LLC    = 3'h4,
    MRSH_FT_SMT    = 3'h5,
    MRSH_FT_IMPL   = 3'h6,
    MRSH_FT_RSVD   = 3'h7
  } mrsh_frame_e;

  typedef logic [`MRSH_RS_W-1:0] mrsh_code_t;

  // ---------------------------------------------------------------
  // Encoder state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       [`MRSH_NCLS-1:0] pend;
    mrsh_code_t [`MRSH_NCLS-1:0] code;
    logic                        ext_seen;
    logic                        ring_prev;
    mrsh_code_t                  rs;
  } mrsh_state_s;

endpackage

// ===== mrsh_dly.sv
module mrsh_dly #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire logic [W-1:0]              d_i,
  output logic      [DEPTH-1:0][W-1:0]   taps_o
);

  // ---------------------------------------------------------------
  // Shift register, tap k is delayed by k+1 clocks
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] stage;
  } mrsh_dly_s;

  mrsh_dly_s st_r;
  mrsh_dly_s st_nxt;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.stage[0] = d_i;
    for (int k = 1; k < DEPTH; k++) begin
      st_nxt.stage[k] = st_r.stage[k-1];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign taps_o = st_r.stage;

endmodule

// ===== mrsh_station.sv
module mrsh_station (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [4:0] rx_status_lines_i,
  input  wire logic       ext_req_i,
  output logic            ext_dest_match_in_n_o,
  output logic            own_frame_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic ft_seen_r;

  // ---------------------------------------------------------------
  // Frame type decode, then only the top two bits next cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ft_seen_r <= 1'b0;
    end else begin
      ft_seen_r <= rx_status_lines_i inside {[5'h01:5'h06]};
    end
  end

  assign own_frame_o = ft_seen_r && (rx_status_lines_i[4:3] == 2'b10);

  // External match request, active low on the wire
  assign ext_dest_match_in_n_o = !ext_req_i;
endmodule

// ===== mac_rx_status_and_hold_tb.sv
module mac_rx_status_and_hold_tb;
  import mrsh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [4:0] code; int at;} mrsh_exp_s;

  logic clk = 0, reset = 1, sel = 0, pin = 0, req = 0, sd = 0, sd_long = 0;
  logic fend = 0, fvalid = 0, own_sa = 0, dmatch = 0, store_fail = 0, ext_req = 0;
  logic tend = 0, trestr = 0, tcapt = 0, ring = 0, ext_armed = 0;
  mrsh_frame_e ftype = MRSH_FT_NONE;
  mrsh_ind_e   e_ind = MRSH_IND_RESET, a_ind = MRSH_IND_RESET, c_ind = MRSH_IND_RESET;
  logic        freeze, tx_start, ext_n, own_seen, prev_ft;
  logic [4:0]  rs;
  int          cyc = 0, n_mismatch = 0, checks = 0;
  mrsh_exp_s   expq[$];
  mrsh_exp_s   mon_x;

  initial begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  mrsh_rx_status DUT (
    .clk_i(clk), .reset_i(reset), .freeze_select_i(sel), .freeze_or_tx_block_pin_i(pin),
    .tx_start_req_i(req), .freeze_o(freeze), .tx_start_o(tx_start), .sd_rcvd_i(sd),
    .sd_long_addr_i(sd_long), .frame_end_i(fend), .frame_valid_i(fvalid), .frame_type_i(ftype),
    .own_sa_match_i(own_sa), .e_ind_i(e_ind), .a_ind_i(a_ind), .c_ind_i(c_ind),
    .dest_match_i(dmatch), .ext_dest_match_in_n_i(ext_n), .buffer_store_fail_i(store_fail),
    .token_end_i(tend), .token_restricted_i(trestr), .token_captured_i(tcapt),
    .ring_operational_i(ring), .rx_status_lines_o(rs)
  );

  mrsh_station station (
    .clk_i(clk), .reset_i(reset), .rx_status_lines_i(rs), .ext_req_i(ext_req),
    .ext_dest_match_in_n_o(ext_n), .own_frame_o(own_seen)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic note(logic [4:0] code, int dly);
    mrsh_exp_s x;
    x.code = code;
    x.at = cyc + dly;
    expq.push_back(x);
  endtask

  task automatic idle(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic done(string name);
    idle(8);
    $display("Test %s finished", name);
  endtask

  function automatic logic [4:0] own_code(mrsh_ind_e e, mrsh_ind_e a, mrsh_ind_e c);
    logic [1:0] ac;
    ac = (a == MRSH_IND_OTHER || c == MRSH_IND_OTHER) ? 2'b01 : {a == MRSH_IND_SET, c == MRSH_IND_SET};
    return {2'b10, e != MRSH_IND_RESET, ac};
  endfunction

  task automatic frame(mrsh_frame_e t, logic v, logic own, mrsh_ind_e e, mrsh_ind_e a, mrsh_ind_e c,
                       logic dm, logic sf, int gap);
    @(negedge clk);
    fend = 1; ftype = t; fvalid = v; own_sa = own; e_ind = e; a_ind = a; c_ind = c;
    dmatch = dm; store_fail = sf;
    if (v && e == MRSH_IND_RESET && t inside {[MRSH_FT_CLAIM:MRSH_FT_IMPL]}) note({2'b00, t}, 2);
    if (own) note(own_code(e, a, c), 3);
    if ((dm || ext_armed) && sf) note(5'h1e, own ? 4 : 3);
    if (gap > 0) begin
      @(negedge clk);
      fend = 0; own_sa = 0; dmatch = 0; store_fail = 0;
      idle(gap);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Monitor: each non-quiet code matches the oldest note
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    if (reset) begin
      check("status in reset", 5'h00, rs);
    end else if (rs !== 5'h00) begin
      if (expq.size() == 0) begin
        check("unexpected status", 5'h00, rs);
      end else begin
        mon_x = expq.pop_front();
        check("status code", mon_x.code, rs);
        check("status cycle", mon_x.at, cyc);
      end
      if (rs[4:3] == 2'b10) check("own frame decode", prev_ft, own_seen);
    end
    prev_ft = rs inside {[5'h01:5'h06]};
  end

  initial begin
    #(50 * 4000);
    n_mismatch++;
    $display("ERROR watchdog expected end seen timeout");
    conclude();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(80));
    idle(6);
    reset = 0;
    idle(2);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      {sel, pin, req} = 3'(i);
      #1;
      check("freeze", sel & pin, freeze);
      check("tx start", req & !pin, tx_start);
    end
    @(negedge clk);
    pin = 0;
    req = 1'($urandom);
    done("hold");
    for (int l = 0; l < 2; l++) begin
      @(negedge clk);
      sd = 1; sd_long = l[0]; ext_armed = 0;
      note(l ? 5'h0c : 5'h08, 2);
      @(negedge clk);
      sd = 0;
      idle(4);
    end
    done("start delimiter");
    for (int t = 1; t <= 6; t++) begin
      frame(mrsh_frame_e'(3'(t)), 1, 0, MRSH_IND_RESET, MRSH_IND_SET, MRSH_IND_SET, 0, 0, 0);
    end
    @(negedge clk);
    fend = 0;
    done("frame types");
    frame(MRSH_FT_LLC, 0, 0, MRSH_IND_RESET, MRSH_IND_RESET, MRSH_IND_RESET, 0, 0, 5);
    frame(MRSH_FT_SMT, 1, 0, MRSH_IND_SET, MRSH_IND_RESET, MRSH_IND_RESET, 0, 0, 5);
    frame(MRSH_FT_RSVD, 1, 0, MRSH_IND_RESET, MRSH_IND_RESET, MRSH_IND_RESET, 0, 0, 5);
    frame(MRSH_FT_NONE, 1, 0, MRSH_IND_RESET, MRSH_IND_RESET, MRSH_IND_RESET, 0, 0, 5);
    done("refused frames");
    for (int k = 0; k < 16; k++) begin
      frame(mrsh_frame_e'(3'(1 + $urandom % 6)), 1, 1, mrsh_ind_e'(2'($urandom % 3)),
            mrsh_ind_e'(2'($urandom % 3)), mrsh_ind_e'(2'($urandom % 3)), 1'($urandom), 1'($urandom), 6);
    end
    done("own frames");
    @(negedge clk);
    ext_req = 1; ext_armed = 1;
    @(negedge clk);
    ext_req = 0;
    idle(2);
    frame(MRSH_FT_LLC, 1, 0, MRSH_IND_RESET, MRSH_IND_RESET, MRSH_IND_RESET, 0, 1, 6);
    @(negedge clk);
    sd = 1; sd_long = 0; ext_armed = 0;
    note(5'h08, 2);
    @(negedge clk);
    sd = 0;
    idle(4);
    frame(MRSH_FT_LLC, 1, 0, MRSH_IND_RESET, MRSH_IND_RESET, MRSH_IND_RESET, 0, 1, 6);
    frame(MRSH_FT_LLC, 1, 0, MRSH_IND_RESET, MRSH_IND_RESET, MRSH_IND_RESET, 1, 0, 6);
    frame(MRSH_FT_LLC, 0, 0, MRSH_IND_RESET, MRSH_IND_RESET, MRSH_IND_RESET, 1, 1, 6);
    done("missed frame");
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      tend = 1; tcapt = i[1]; trestr = i[0];
      note({3'b110, i[1:0]}, 3);
    end
    @(negedge clk);
    tend = 0;
    done("tokens");
    frame(MRSH_FT_SMT, 1, 0, MRSH_IND_RESET, MRSH_IND_RESET, MRSH_IND_RESET, 0, 0, 0);
    @(negedge clk);
    fend = 0; ring = 1;
    note(5'h1c, 2);
    idle(5);
    ring = 0;
    note(5'h1d, 1);
    done("ring");
    @(negedge clk);
    tend = 1; tcapt = 1; trestr = 1;
    @(negedge clk);
    tend = 0; reset = 1;
    @(negedge clk);
    reset = 0;
    done("reset");
    check("pending notes", 0, expq.size());
    conclude();
  end
endmodule
